// >>> hdl/value_select_pkg.sv
// shared constants, carriers and source codes for the value selector
// assumes one 100 MHz clock domain; all pins already synchronous
package value_select_pkg;
    // decade geometry: up to ten fields of 1-2-4-8 weighted bcd
    localparam int unsigned DIGITS_MAX = 10;
    localparam int unsigned BCD_W = 4;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] DIGIT_RST = 4'h0;

    // select pair levels that mean "remote": first pin low, second high
    localparam logic PAIR_A_REMOTE = 1'b0;
    localparam logic PAIR_B_REMOTE = 1'b1;
    // override pin levels that mean "active"
    localparam logic OPEN_ACTIVE = 1'b0;
    localparam logic SHORT_ACTIVE = 1'b1;

    // reset values of the indicator and override state
    localparam logic READY_RST = 1'b1;
    localparam logic OPEN_RST = 1'b0;
    localparam logic SHORT_RST = 1'b0;
    localparam logic CMD_REMOTE_RST = 1'b0;

    typedef logic [DIGITS_MAX-1:0][BCD_W-1:0] digit_vec_t;

    typedef enum logic [1:0] {
        SRC_LOCAL = 2'b00,
        SRC_BCD = 2'b01,
        SRC_CMD = 2'b10
    } source_t;

    // parallel connector lines from the external controller
    typedef struct packed {
        logic sel_local;
        logic sel_remote;
        logic open_n;
        logic short_req;
        digit_vec_t digits;
    } bcd_pins_t;

    // decoded command traffic from a bus or serial option
    typedef struct packed {
        logic init;
        logic write;
        logic release_req;
        logic open_req;
        logic short_req;
        digit_vec_t digits;
    } cmd_port_t;

    // build options of the unit
    typedef struct packed {
        logic present;
        logic is_cmd;
        logic short_fitted;
    } option_cfg_t;
endpackage

// >>> hdl/digit_slot.sv
// one decade: picks local or remote digit, holds on a non-bcd code
// assumes use_remote_i is the source decision of the same cycle
`timescale 1ns/10ps
module digit_slot #(
    parameter bit FITTED = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] local_digit_i,
    input wire logic [3:0] remote_digit_i,
    input wire logic use_remote_i,
    output logic [3:0] digit_o
);
    import value_select_pkg::*;

    logic [3:0] digit_q;
    logic [3:0] digit_d;
    logic [3:0] pick;

    // unfitted decades stay at zero whatever the pins carry
    always_comb begin
        pick = use_remote_i ? remote_digit_i : local_digit_i;
        digit_d = digit_q;
        if (!FITTED) begin
            digit_d = DIGIT_RST;
        end else if (pick <= BCD_MAX) begin
            digit_d = pick;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            digit_q <= DIGIT_RST;
        end else begin
            digit_q <= digit_d;
        end
    end

    assign digit_o = digit_q;

    // codes 10..15 are not decimal; holding avoids a bogus setting
    a_digit_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (FITTED && pick > BCD_MAX) |=> digit_o == $past(digit_o))
        else $error("non-bcd digit changed the decade");
endmodule

// >>> hdl/value_selector.sv
// source selection for the decade value, indicators and overrides
// assumes pins are synchronous to ref_clk_i; outputs lag inputs 1 cycle
`timescale 1ns/10ps
module value_selector #(
    parameter int unsigned FITTED_DECADES = value_select_pkg::DIGITS_MAX
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic panel_remote_i,
    input wire value_select_pkg::option_cfg_t option_i,
    input wire value_select_pkg::digit_vec_t thumb_digits_i,
    input wire value_select_pkg::bcd_pins_t bcd_i,
    input wire value_select_pkg::cmd_port_t cmd_i,
    output value_select_pkg::digit_vec_t value_o,
    output logic open_o,
    output logic short_o,
    output logic remote_led_o,
    output logic local_led_o,
    output logic ready_led_o
);
    import value_select_pkg::*;

    source_t source_q;
    source_t source_d;
    logic cmd_remote_q;
    logic cmd_remote_d;
    digit_vec_t cmd_val_q;
    digit_vec_t cmd_val_d;
    logic cmd_open_q;
    logic cmd_open_d;
    logic cmd_short_q;
    logic cmd_short_d;
    logic open_q;
    logic open_d;
    logic short_q;
    logic short_d;
    logic ready_q;
    logic ready_d;
    logic bcd_claim;
    logic open_req;
    logic short_req;
    digit_vec_t remote_digits;

    // a half-driven or equal pair is no claim; that keeps a dangling
    // cable from snatching control
    assign bcd_claim = (bcd_i.sel_local == PAIR_A_REMOTE)
        && (bcd_i.sel_remote == PAIR_B_REMOTE);

    // command side: latch value and overrides on each write
    always_comb begin
        cmd_val_d = cmd_val_q;
        cmd_open_d = cmd_open_q;
        cmd_short_d = cmd_short_q;
        if (cmd_i.write) begin
            cmd_val_d = cmd_i.digits;
            cmd_open_d = cmd_i.open_req;
            cmd_short_d = cmd_i.short_req;
        end
        // a write in the release cycle keeps remote: set beats clear
        cmd_remote_d = cmd_i.init
            && (cmd_i.write || (cmd_remote_q && !cmd_i.release_req));
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_val_q <= '0;
            cmd_open_q <= OPEN_RST;
            cmd_short_q <= SHORT_RST;
            cmd_remote_q <= CMD_REMOTE_RST;
        end else begin
            cmd_val_q <= cmd_val_d;
            cmd_open_q <= cmd_open_d;
            cmd_short_q <= cmd_short_d;
            cmd_remote_q <= cmd_remote_d;
        end
    end

    // source decision, panel switch first, then the option's claim
    always_comb begin
        source_d = SRC_LOCAL;
        if (!panel_remote_i || !option_i.present) begin
            source_d = SRC_LOCAL;
        end else if (option_i.is_cmd) begin
            if (cmd_remote_d) begin
                source_d = SRC_CMD;
            end
        end else if (bcd_claim) begin
            source_d = SRC_BCD;
        end
    end

    // overrides decoded per source; thumbwheels have no path to them
    always_comb begin
        open_req = 1'b0;
        short_req = 1'b0;
        unique case (source_d)
            SRC_LOCAL: begin
                open_req = 1'b0;
                short_req = 1'b0;
            end
            SRC_BCD: begin
                open_req = (bcd_i.open_n == OPEN_ACTIVE);
                short_req = option_i.short_fitted
                    && (bcd_i.short_req == SHORT_ACTIVE);
            end
            SRC_CMD: begin
                open_req = cmd_open_d;
                short_req = option_i.short_fitted && cmd_short_d;
            end
            default: begin
                open_req = 1'b0;
                short_req = 1'b0;
            end
        endcase
        // floating lines read high on open, low on short: inactive
        short_d = short_req;
        open_d = open_req && !short_req;
        ready_d = option_i.present;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            source_q <= SRC_LOCAL;
            open_q <= OPEN_RST;
            short_q <= SHORT_RST;
            ready_q <= READY_RST;
        end else begin
            source_q <= source_d;
            open_q <= open_d;
            short_q <= short_d;
            ready_q <= ready_d;
        end
    end

    // remote digits come from whichever option is in control
    assign remote_digits = (source_d == SRC_CMD) ? cmd_val_d : bcd_i.digits;

    // one slot per decade field; extra fields are tied off inside
    for (genvar i = 0; i < DIGITS_MAX; i++) begin : g_slot
        digit_slot #(
            .FITTED(i < FITTED_DECADES)
        ) u_slot (
            .ref_clk_i(ref_clk_i),
            .rst_i(rst_i),
            .local_digit_i(thumb_digits_i[i]),
            .remote_digit_i(remote_digits[i]),
            .use_remote_i(source_d != SRC_LOCAL),
            .digit_o(value_o[i])
        );
    end

    // indicators follow the registered source, so never disagree
    assign remote_led_o = (source_q != SRC_LOCAL);
    assign local_led_o = (source_q == SRC_LOCAL);
    assign open_o = open_q;
    assign short_o = short_q;
    assign ready_led_o = ready_q;

    a_panel_local: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !panel_remote_i |=> source_q == SRC_LOCAL && !open_o)
        else $error("panel local did not force thumbwheel source");

    a_local_value: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!panel_remote_i && thumb_digits_i[0] <= BCD_MAX)
        |=> value_o[0] == $past(thumb_digits_i[0]))
        else $error("thumbwheel digit not passed in local");

    a_no_claim: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (panel_remote_i && option_i.present && !option_i.is_cmd
        && !bcd_claim) |=> source_q == SRC_LOCAL)
        else $error("remote source without a claim");

    a_bad_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (bcd_i.sel_local == bcd_i.sel_remote) && !option_i.is_cmd
        |=> source_q != SRC_BCD)
        else $error("invalid select pair gave remote control");

    a_bcd_take: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (panel_remote_i && option_i.present && !option_i.is_cmd && bcd_claim
        && bcd_i.digits[0] <= BCD_MAX)
        |=> source_q == SRC_BCD && value_o[0] == $past(bcd_i.digits[0]))
        else $error("connector digit not taken under remote");

    a_led_pair: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        remote_led_o != local_led_o
        && (!remote_led_o || $past(panel_remote_i && option_i.present)))
        else $error("indicators disagree with source");

    a_unfitted_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (FITTED_DECADES >= DIGITS_MAX) || value_o[DIGITS_MAX-1] == '0)
        else $error("unfitted decade not zero");

    a_open_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (source_d == SRC_BCD && bcd_i.open_n == OPEN_ACTIVE
        && !(option_i.short_fitted && bcd_i.short_req))
        |=> open_o && !short_o)
        else $error("open input low did not open");

    a_short_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (source_d == SRC_BCD && option_i.short_fitted
        && bcd_i.short_req == SHORT_ACTIVE) |=> short_o && !open_o)
        else $error("short did not take priority");

    a_idle_pins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (source_d == SRC_BCD && bcd_i.open_n && !bcd_i.short_req)
        |=> !open_o && !short_o)
        else $error("inactive override levels acted");

    a_local_plain: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        local_led_o |-> !open_o && !short_o)
        else $error("override reached without remote option");

    a_cmd_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !cmd_i.init |=> source_q != SRC_CMD)
        else $error("command source before initialisation");

    a_ready_lamp: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        option_i.present |=> ready_led_o)
        else $error("ready indicator off with option fitted");

    c_bcd_remote: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        local_led_o ##1 remote_led_o && source_q == SRC_BCD);
    c_cmd_remote: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        source_q == SRC_CMD && value_o[0] != thumb_digits_i[0]);
    c_short_over_open: cover property (@(posedge ref_clk_i)
        disable iff (rst_i) short_o && !bcd_i.open_n);
    c_back_local: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        remote_led_o ##1 local_led_o);
endmodule

// >>> test/bcd_controller.sv
// model of the external controller on the parallel bcd connector
// assumes the bench gives the claim, levels and digits it wants shown
`timescale 1ns/10ps
module bcd_controller #(
    parameter int unsigned FITTED = 10
) (
    input wire logic ref_clk_i,
    input wire logic claim_i,
    input wire logic break_pair_i,
    input wire logic open_i,
    input wire logic short_i,
    input wire value_select_pkg::digit_vec_t digits_i,
    output value_select_pkg::bcd_pins_t pins_o
);
    import value_select_pkg::*;
    logic [3:0] churn_q = 4'h0;

    // unused decades float: a changing pattern, not a stable last value
    always @(posedge ref_clk_i) begin
        churn_q <= churn_q + 4'h1;
    end

    // select pair complementary; break drives both low, not a selection
    always_comb begin
        pins_o.sel_local = !claim_i & !break_pair_i;
        pins_o.sel_remote = claim_i & !break_pair_i;
        pins_o.open_n = !open_i;
        pins_o.short_req = short_i;
        for (int i = 0; i < DIGITS_MAX; i++) begin
            pins_o.digits[i] = (i < FITTED) ? digits_i[i] : churn_q;
        end
    end
endmodule

// >>> test/value_selector_test.sv
// self-checking bench for the value selector with random stimulus
// assumes a 1-cycle output lag and six fitted decades
`timescale 1ns/10ps
module value_selector_test;
    import value_select_pkg::*;
    localparam int FD = 6;
    typedef struct packed {
        logic [31:0] due;
        digit_vec_t v;
        logic op, sh, rl, ll, rd;
    } note_t;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic panel = 1'b0, claim = 1'b0, brk = 1'b0, ro = 1'b0, rsh = 1'b0;
    option_cfg_t opt = '0;
    digit_vec_t thumb = '0, rdig = '0, value_o, e_v = '0, c_val = '0;
    cmd_port_t cmd = '0;
    bcd_pins_t pins;
    logic open_o, short_o, remote_led_o, local_led_o, ready_led_o;
    logic c_rem = 1'b0, c_op = 1'b0, c_sh = 1'b0;
    logic [31:0] rs = 32'he42c;
    int num_errors = 0, checks = 0, cnt = 0;
    note_t q[$];
    note_t m_n;

    always #5 ref_clk_i = ~ref_clk_i;

    bcd_controller #(.FITTED(FD)) PEER (.ref_clk_i(ref_clk_i),
        .claim_i(claim), .break_pair_i(brk), .open_i(ro), .short_i(rsh),
        .digits_i(rdig), .pins_o(pins));
    value_selector #(.FITTED_DECADES(FD)) DUT (.ref_clk_i(ref_clk_i),
        .rst_i(rst_i), .panel_remote_i(panel), .option_i(opt),
        .thumb_digits_i(thumb), .bcd_i(pins), .cmd_i(cmd),
        .value_o(value_o), .open_o(open_o), .short_o(short_o),
        .remote_led_o(remote_led_o), .local_led_o(local_led_o),
        .ready_led_o(ready_led_o));

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    // reference: source pick, command latch, per-decade hold
    task automatic push();
        source_t s;
        digit_vec_t src;
        note_t n;
        s = SRC_LOCAL;
        if (cmd.write) begin
            c_val = cmd.digits;
            c_op = cmd.open_req;
            c_sh = cmd.short_req;
        end
        c_rem = cmd.init && (cmd.write || (c_rem && !cmd.release_req));
        if (panel && opt.present) begin
            if (opt.is_cmd) begin
                if (c_rem) s = SRC_CMD;
            end else if (!pins.sel_local && pins.sel_remote) s = SRC_BCD;
        end
        src = (s == SRC_CMD) ? c_val : (s == SRC_BCD) ? pins.digits : thumb;
        for (int i = 0; i < DIGITS_MAX; i++) begin
            if (i >= FD) e_v[i] = DIGIT_RST;
            else if (src[i] <= BCD_MAX) e_v[i] = src[i];
        end
        n.sh = s != SRC_LOCAL && opt.short_fitted &&
               ((s == SRC_CMD) ? c_sh : pins.short_req == SHORT_ACTIVE);
        n.op = s != SRC_LOCAL && !n.sh &&
               ((s == SRC_CMD) ? c_op : pins.open_n == OPEN_ACTIVE);
        n.rl = s != SRC_LOCAL;
        n.ll = !n.rl;
        n.rd = opt.present;
        n.v = e_v;
        n.due = cnt + 1;
        q.push_back(n);
    endtask

    // monitor: settles 3 ns past the edge, then takes the oldest due note
    always @(posedge ref_clk_i) begin
        cnt++;
        #3;
        if (q.size() > 0 && q[0].due == cnt) begin
            m_n = q.pop_front();
            chk(value_o, m_n.v, "value");
            chk(40'(open_o), 40'(m_n.op), "open");
            chk(40'(short_o), 40'(m_n.sh), "short");
            chk(40'(remote_led_o), 40'(m_n.rl), "remote lamp");
            chk(40'(local_led_o), 40'(m_n.ll), "local lamp");
            chk(40'(ready_led_o), 40'(m_n.rd), "ready lamp");
        end
    end

    // mode 0 parallel connector, mode 1 command option, panel mostly remote
    task automatic run(input logic mode, input int n, input string name);
        logic [31:0] r;
        for (int k = 0; k < n; k++) begin
            @(posedge ref_clk_i);
            #1;
            r = rnd();
            panel = r[0] | r[1] | (mode & r[17]);
            opt = '{present: mode | r[2] | r[3], is_cmd: mode,
                    short_fitted: r[4]};
            claim = r[5] | r[6];
            brk = r[7] & r[8];
            ro = r[9];
            rsh = r[10];
            cmd.init = mode & (r[11] | r[12] | r[20]);
            cmd.write = mode & r[13] & r[14];
            cmd.release_req = mode & r[15] & r[16];
            cmd.open_req = r[18];
            cmd.short_req = r[19];
            thumb = 40'({rnd(), rnd()});
            rdig = 40'({rnd(), rnd()});
            cmd.digits = 40'({rnd(), rnd()});
            #1;
            push();
        end
        $display("test %s done, errors %0d", name, num_errors);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // reset lamps, both phases, then a bounded drain of the notes
    initial begin
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk(40'(local_led_o), 40'h1, "reset local");
        chk(40'(ready_led_o), 40'(READY_RST), "reset ready");
        rst_i = 1'b0;
        run(1'b0, 600, "parallel");
        run(1'b1, 600, "command");
        for (int i = 0; i < 5 && q.size() > 0; i++) @(posedge ref_clk_i);
        #5;
        if (q.size() > 0) begin
            num_errors++;
            $display("mismatch at %0t: notes left unchecked", $time);
        end
        report_and_stop();
    end
endmodule
